// ===== dv/ddrt_assertions.sv
// Port checker of the command timing enforcer
`timescale 1ns/100ps
module ddrt_assertions #(
    parameter int NBANK = 8,
    parameter int BANK_W = 3
) (
    // System
    input wire logic clk,
    input wire logic srst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ddrt_pkg::ADDR_W-1:0] paddr,
    input wire logic [ddrt_pkg::DATA_W-1:0] pwdata,
    input wire logic [ddrt_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic initStart,
    // Link
    input wire logic memClk,
    input wire logic cmdValid,
    input wire ddrt_pkg::ddrt_cmd_t cmdType,
    input wire logic [BANK_W-1:0] cmdBank,
    input wire logic cmdIssue,
    input wire ddrt_pkg::ddrt_cmd_t cmdIssueType,
    input wire logic [BANK_W-1:0] cmdIssueBank,
    input wire logic memCke
);
    logic mapped;
    logic tim1Wr;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    assign tim1Wr = psel && penable && pready && pwrite &&
        paddr == ddrt_pkg::OFS_TIM1;
    sequence s_sr_enter;
        cmdIssue && cmdIssueType == ddrt_pkg::CMD_SR_ENTER;
    endsequence
    a_ready_wait: assert property (@(posedge clk) disable iff (srst)
        psel && penable && !pready |=> pready) else $error("pready late");
    a_ready_once: assert property (@(posedge clk) disable iff (srst)
        pready |=> !pready) else $error("pready too long");
    a_err_map: assert property (@(posedge clk) disable iff (srst)
        pready |-> pslverr == !mapped) else $error("pslverr wrong");
    a_err_zero: assert property (@(posedge clk) disable iff (srst)
        pready && pslverr && !pwrite |-> prdata == '0)
        else $error("unmapped read not zero");
    a_tim2_rsvd: assert property (@(posedge clk) disable iff (srst)
        pready && !pwrite && paddr == ddrt_pkg::OFS_TIM2 |->
        prdata[31:25] == 7'h00) else $error("secondary top bits set");
    a_init_cause: assert property (@(posedge clk) disable iff (srst)
        initStart |-> $past(tim1Wr) || $past(tim1Wr, 2))
        else $error("init without timing write");
    a_init_once: assert property (@(posedge clk) disable iff (srst)
        initStart |=> !initStart) else $error("init pulse too long");
    a_issue_gap: assert property (@(posedge memClk) disable iff (srst)
        cmdIssue |=> !cmdIssue) else $error("issues back to back");
    a_issue_echo: assert property (@(posedge memClk) disable iff (srst)
        $rose(cmdIssue) |-> $past(cmdValid) &&
        cmdIssueType == $past(cmdType) && cmdIssueBank == $past(cmdBank))
        else $error("issued command differs from request");
    a_cke_low: assert property (@(posedge memClk) disable iff (srst)
        s_sr_enter |-> ##[0:2] !memCke) else $error("cke kept high");
endmodule : ddrt_assertions

// ===== dv/ddrt_ddr2_model.sv
// Behavioural DDR2 device that times and screens issued commands
`timescale 1ns/100ps
module ddrt_ddr2_model (
    // Link
    input wire logic memClk,
    input wire logic srst,
    input wire logic cmdIssue,
    input wire ddrt_pkg::ddrt_cmd_t cmdIssueType,
    // Observations
    output int gap,
    output int badCmds
);
    int cyc;
    int last;
    logic inSr;
    assign gap = cyc - last;
    always_ff @(posedge memClk) begin
        if (srst) begin
            cyc <= 0;
            last <= 0;
            inSr <= 1'b0;
            badCmds <= 0;
        end else begin
            cyc <= cyc + 1;
            if (cmdIssue) begin
                last <= cyc;
                inSr <= cmdIssueType == ddrt_pkg::CMD_SR_ENTER;
                // Asleep only the exit is legal, awake never
                if (inSr != (cmdIssueType == ddrt_pkg::CMD_SR_EXIT)) begin
                    badCmds <= badCmds + 1;
                end
            end
        end
    end
endmodule : ddrt_ddr2_model

// ===== dv/testbench.sv
// Self-checking bench of the command timing enforcer
`timescale 1ns/100ps
module testbench;
    logic clk = 0;
    logic memClk = 0;
    logic srst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, initStart, cmdIssue, memCke;
    logic cmdValid = 0;
    ddrt_pkg::ddrt_cmd_t cmdType = ddrt_pkg::CMD_REFRESH;
    ddrt_pkg::ddrt_cmd_t cmdIssueType;
    logic [2:0] cmdBank = '0;
    logic [2:0] cmdIssueBank;
    logic [32:0] rdq[$];
    logic [13:0] lq[$];
    logic [31:0] t1, t2, rd;
    int gap, badCmds, n_mismatch = 0, checked = 0, seed = 39, nInit = 0;
    int rfc, rp, rcd, wr, ras, rc, rrd, wtr, xsnr, xsrd, rtp, cke;
    ddrt_timing_enforcer i_dut (.*);
    ddrt_ddr2_model i_mem (.*);
    always #10 clk = ~clk;
    // Phase offset keeps the two clocks unrelated
    initial begin
        #7;
        forever #15 memClk = ~memClk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("Mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    function automatic int rnd(input int m);
        return $unsigned($random(seed)) % m;
    endfunction : rnd
    function automatic int mx(input int f);
        return (f < 1) ? 2 : f + 1;
    endfunction : mx
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wrx(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd);
    endtask : wrx
    task automatic rdx(input logic [7:0] a, input logic [31:0] e,
            input logic err);
        rdq.push_back({err, e});
        apb(1'b0, a, '0, rd);
    endtask : rdx
    task automatic cmd(input ddrt_pkg::ddrt_cmd_t t, input int b,
            input int mn);
        lq.push_back({t, b[2:0], mn[7:0]});
        @(posedge memClk);
        cmdValid <= 1'b1;
        cmdType <= t;
        cmdBank <= b[2:0];
        do @(posedge memClk); while (cmdIssue !== 1'b1);
        cmdValid <= 1'b0;
    endtask : cmd
    always @(posedge clk) begin
        if (initStart === 1'b1) nInit++;
        if (psel && penable && pready === 1'b1 && !pwrite && rdq.size()) begin
            check({31'h0, pslverr}, {31'h0, rdq[0][32]});
            check(prdata, rdq[0][31:0]);
            void'(rdq.pop_front());
        end
    end
    always @(posedge memClk) begin
        if (cmdIssue === 1'b1) begin
            if (lq.size() == 0) check(32'h0, 32'h1);
            else begin
                check(cmdIssueType, lq[0][13:11]);
                check(cmdIssueBank, lq[0][10:8]);
                check({31'h0, gap >= int'(lq[0][7:0])}, 32'h1);
                void'(lq.pop_front());
            end
        end
    end
    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rdx(ddrt_pkg::OFS_STATUS, 32'h0, 1'b0);
        rdx(ddrt_pkg::OFS_BANKCFG, 32'h0, 1'b0);
        rdx(ddrt_pkg::OFS_REFRESH, 32'h884, 1'b0);
        rdx(ddrt_pkg::OFS_TIM2, 32'h001df145, 1'b0);
        rdx(8'h20, 32'h0, 1'b1);
        wrx(ddrt_pkg::OFS_TIM1, 32'h0);
        rdx(ddrt_pkg::OFS_TIM1, ddrt_pkg::TIM1_RST, 1'b0);
        wrx(ddrt_pkg::OFS_BANKCFG, 32'h8000);
        rdx(ddrt_pkg::OFS_BANKCFG, 32'h8000, 1'b0);
        wrx(ddrt_pkg::OFS_TIM2, 32'hffffffff);
        rdx(ddrt_pkg::OFS_TIM2, 32'h01ffffff, 1'b0);
        {xsnr, xsrd, rtp, cke} = {rnd(16), rnd(16), rnd(8), rnd(8)};
        t2 = 32'h01800000 | xsnr << 16 | xsrd << 8 | rtp << 5 | cke;
        wrx(ddrt_pkg::OFS_TIM2, t2);
        rdx(ddrt_pkg::OFS_TIM2, t2, 1'b0);
        {rfc, rp, rcd, wr, rc, wtr} = {rnd(8), rnd(8), rnd(8), rnd(4),
            rnd(16), rnd(4)};
        ras = rcd + rnd(4);
        rrd = rnd(4);
        t1 = rfc << 25 | rp << 22 | rcd << 19 | wr << 16 | ras << 11 |
            rc << 6 | rrd << 3 | wtr;
        // Write recovery always moves off its reset value of 7
        repeat (2) begin
            wrx(ddrt_pkg::OFS_TIM1, t1);
            repeat (3) @(posedge clk);
            check(nInit, 32'h1);
        end
        rdx(ddrt_pkg::OFS_TIM1, t1, 1'b0);
        wrx(ddrt_pkg::OFS_REFRESH, 32'h00ff);
        rdx(ddrt_pkg::OFS_REFRESH, 2 * rfc, 1'b0);
        wrx(ddrt_pkg::OFS_REFRESH, 32'h0100);
        rdx(ddrt_pkg::OFS_REFRESH, 32'h0100, 1'b0);
        wrx(ddrt_pkg::OFS_BANKCFG, 32'h0);
        wrx(ddrt_pkg::OFS_TIM1, 32'h0);
        wrx(ddrt_pkg::OFS_TIM2, 32'h0);
        rdx(ddrt_pkg::OFS_TIM1, t1, 1'b0);
        rdx(ddrt_pkg::OFS_TIM2, t2, 1'b0);
        check(nInit, 32'h1);
        do apb(1'b0, ddrt_pkg::OFS_STATUS, '0, rd); while (rd[1] !== 1'b0);
        repeat (4) @(posedge memClk);
        cmd(ddrt_pkg::CMD_REFRESH, 0, 0);
        cmd(ddrt_pkg::CMD_ACTIVATE, 0, mx(rfc));
        cmd(ddrt_pkg::CMD_WRITE, 0, mx(rcd));
        cmd(ddrt_pkg::CMD_READ, 0, mx(wtr));
        cmd(ddrt_pkg::CMD_PRECHARGE, 0, mx(rtp));
        cmd(ddrt_pkg::CMD_ACTIVATE, 0, mx(rp));
        cmd(ddrt_pkg::CMD_ACTIVATE, 1, mx(rrd));
        cmd(ddrt_pkg::CMD_ACTIVATE, 1, mx(rc));
        cmd(ddrt_pkg::CMD_WRITE, 1, mx(rcd));
        cmd(ddrt_pkg::CMD_PRECHARGE, 1, mx(wr));
        cmd(ddrt_pkg::CMD_ACTIVATE, 2, mx(rp));
        cmd(ddrt_pkg::CMD_PRECHARGE, 2, mx(ras));
        cmd(ddrt_pkg::CMD_LOAD_MODE, 0, 2);
        cmd(ddrt_pkg::CMD_REFRESH, 0, mx(rfc));
        cmd(ddrt_pkg::CMD_SR_ENTER, 0, 2);
        cmd(ddrt_pkg::CMD_SR_EXIT, 0, mx(cke));
        cmd(ddrt_pkg::CMD_SR_ENTER, 0, mx(cke));
        cmd(ddrt_pkg::CMD_SR_EXIT, 0, mx(cke));
        cmd(ddrt_pkg::CMD_REFRESH, 0, mx(xsnr));
        cmd(ddrt_pkg::CMD_SR_ENTER, 0, 2);
        cmd(ddrt_pkg::CMD_SR_EXIT, 0, mx(cke));
        cmd(ddrt_pkg::CMD_READ, 2, mx(xsrd));
        repeat (4) @(posedge memClk);
        check(badCmds, 32'h0);
        check({31'h0, memCke}, 32'h1);
        close_out();
    end
endmodule : testbench
bind ddrt_timing_enforcer ddrt_assertions #(.NBANK(NBANK), .BANK_W(BANK_W))
    u_chk (.*);

// ===== verilog/ddrt_pkg.sv
// Constants, field layouts and types of the command timing enforcer
package ddrt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_BANKCFG = 8'h04;
    localparam logic [7:0] OFS_REFRESH = 8'h08;
    localparam logic [7:0] OFS_TIM1 = 8'h0c;
    localparam logic [7:0] OFS_TIM2 = 8'h10;

    // Status and bank configuration bits
    localparam int STAT_SR_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int UNLOCK_BIT = 15;
    localparam int RATE_W = 16;

    // Reset values and writable masks
    localparam logic [15:0] RATE_RST = 16'h0884;
    localparam logic [15:0] RATE_MIN = 16'h0100;
    localparam logic [31:0] TIM1_RST = 32'hfffffffb;
    localparam logic [31:0] TIM1_MASK = 32'hfffffffb;
    localparam logic [31:0] TIM2_RST = 32'h001df145;
    localparam logic [31:0] TIM2_MASK = 32'h01ffffff;

    // Primary timing register fields
    localparam int RFC_LSB = 25;
    localparam int RFC_W = 7;
    localparam int RP_LSB = 22;
    localparam int RP_W = 3;
    localparam int RCD_LSB = 19;
    localparam int RCD_W = 3;
    localparam int WR_LSB = 16;
    localparam int WR_W = 3;
    localparam int RAS_LSB = 11;
    localparam int RAS_W = 5;
    localparam int RC_LSB = 6;
    localparam int RC_W = 5;
    localparam int RRD_LSB = 3;
    localparam int RRD_W = 3;
    localparam int WTR_LSB = 0;
    localparam int WTR_W = 2;

    // Secondary timing register fields
    localparam int XSNR_LSB = 16;
    localparam int XSNR_W = 7;
    localparam int XSRD_LSB = 8;
    localparam int XSRD_W = 8;
    localparam int RTP_LSB = 5;
    localparam int RTP_W = 3;
    localparam int CKE_LSB = 0;
    localparam int CKE_W = 5;

    typedef enum logic [2:0] {
        CMD_REFRESH,
        CMD_LOAD_MODE,
        CMD_PRECHARGE,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_SR_ENTER,
        CMD_SR_EXIT
    } ddrt_cmd_t;

    typedef enum logic {
        LINK_ACTIVE,
        LINK_SELFREF
    } ddrt_link_t;
endpackage : ddrt_pkg

// ===== verilog/ddrt_timing_enforcer.sv
// DDR2 command timing enforcer with APB timing registers
//
// Contract
// - Refresh/load-mode to refresh/activate waits field+1
// - Precharge to refresh/activate waits field+1
// - Activate to read/write same bank waits
// - Write to precharge waits recovery field+1
// - Changed write recovery value starts initialization
// - Activate to precharge same bank waits
// - Activates to same bank spaced field+1
// - Activates to different banks spaced field+1
// - Write to read waits field+1 cycles
// - Timing writes only accepted while unlocked
// - Self-refresh exit to non-read waits field+1
// - Self-refresh exit to read waits field+1
// - Read to precharge waits field+1 cycles
// - Clock enable held stable field+1 cycles
// - Secondary bits 24:23 writable, 31:25 read zero
// - Refresh rate below 100h loads twice refresh
`timescale 1ns/100ps
module ddrt_timing_enforcer #(
    parameter int NBANK = 8,
    parameter int BANK_W = 3
) (
    // System
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ddrt_pkg::ADDR_W-1:0] paddr,
    input wire logic [ddrt_pkg::DATA_W-1:0] pwdata,
    output logic [ddrt_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Initialization trigger
    output logic initStart,
    // Memory link
    input wire logic memClk,
    input wire logic cmdValid,
    input wire ddrt_pkg::ddrt_cmd_t cmdType,
    input wire logic [BANK_W-1:0] cmdBank,
    output logic cmdIssue,
    output ddrt_pkg::ddrt_cmd_t cmdIssueType,
    output logic [BANK_W-1:0] cmdIssueBank,
    output logic memCke
);
    localparam int CW = ddrt_pkg::CNT_W;

    if (NBANK != (1 << BANK_W)) begin : g_bank_check
        $error("NBANK must equal 2**BANK_W");
    end

    function automatic logic [CW-1:0] fld(input logic [31:0] w,
        input int lsb, input int wd);
        logic [31:0] t;
        t = (w >> lsb) & ((32'h1 << wd) - 32'h1);
        return t[CW-1:0];
    endfunction : fld

    function automatic logic [CW-1:0] dec(input logic [CW-1:0] c);
        return (c == '0) ? c : c - {{(CW-1){1'b0}}, 1'b1};
    endfunction : dec

    // Register side state
    logic [31:0] tim1_reg, tim2_reg, prdata_reg, readWord;
    logic [ddrt_pkg::RATE_W-1:0] rate_reg, rateWrite;
    logic unlock_reg, pready_reg, pslverr_reg, initStart_reg;
    logic srMeta_reg, srSync_reg, syncBusy, mapped, done, wrTiming;

    // Link side state
    logic memRstMeta_reg, memRst_reg, cmdIssue_reg, memCke_reg;
    logic permit, issue, active;
    logic [63:0] timLink;
    logic [31:0] lt1, lt2;
    ddrt_pkg::ddrt_link_t linkState_reg;
    ddrt_pkg::ddrt_cmd_t cmdIssueType_reg;
    logic [BANK_W-1:0] cmdIssueBank_reg;
    logic [CW-1:0] rfcCnt_reg, rpCnt_reg, rrdCnt_reg, wtrCnt_reg;
    logic [CW-1:0] xsnrCnt_reg, xsrdCnt_reg, ckeCnt_reg;
    logic [CW-1:0] rcdCnt_reg [NBANK], rasCnt_reg [NBANK];
    logic [CW-1:0] rcCnt_reg [NBANK], wrCnt_reg [NBANK], rtpCnt_reg [NBANK];

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign initStart = initStart_reg;
    assign cmdIssue = cmdIssue_reg;
    assign cmdIssueType = cmdIssueType_reg;
    assign cmdIssueBank = cmdIssueBank_reg;
    assign memCke = memCke_reg;

    // APB decode: one wait state, answer registered
    always_comb begin
        mapped = 1'b1;
        readWord = 32'h0;
        case (paddr)
            ddrt_pkg::OFS_STATUS: begin
                readWord[ddrt_pkg::STAT_SR_BIT] = srSync_reg;
                readWord[ddrt_pkg::STAT_BUSY_BIT] = syncBusy;
            end
            ddrt_pkg::OFS_BANKCFG: readWord[ddrt_pkg::UNLOCK_BIT] = unlock_reg;
            ddrt_pkg::OFS_REFRESH: readWord[ddrt_pkg::RATE_W-1:0] = rate_reg;
            ddrt_pkg::OFS_TIM1: readWord = tim1_reg;
            ddrt_pkg::OFS_TIM2: readWord = tim2_reg;
            default: mapped = 1'b0;
        endcase
    end

    assign done = psel && penable && pready_reg;
    assign wrTiming = done && pwrite && mapped && unlock_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !mapped;
            if (psel && penable && !pready_reg) begin
                prdata_reg <= pwrite ? 32'h0 : readWord;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            unlock_reg <= 1'b0;
        end else if (done && pwrite && paddr == ddrt_pkg::OFS_BANKCFG) begin
            unlock_reg <= pwdata[ddrt_pkg::UNLOCK_BIT];
        end
    end

    // Short rates fall back to twice the refresh cycle time
    always_comb begin
        rateWrite = pwdata[ddrt_pkg::RATE_W-1:0];
        if (rateWrite < ddrt_pkg::RATE_MIN) begin
            rateWrite = {8'h0, tim1_reg[ddrt_pkg::RFC_LSB +: ddrt_pkg::RFC_W],
                1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rate_reg <= ddrt_pkg::RATE_RST;
        end else if (done && pwrite && paddr == ddrt_pkg::OFS_REFRESH) begin
            rate_reg <= rateWrite;
        end
    end

    // Reserved bits 24:23 reset to zero here, a legal indeterminate value
    always_ff @(posedge clk) begin
        if (srst) begin
            tim1_reg <= ddrt_pkg::TIM1_RST;
            tim2_reg <= ddrt_pkg::TIM2_RST;
        end else if (wrTiming) begin
            if (paddr == ddrt_pkg::OFS_TIM1) begin
                tim1_reg <= pwdata & ddrt_pkg::TIM1_MASK;
            end
            if (paddr == ddrt_pkg::OFS_TIM2) begin
                tim2_reg <= pwdata & ddrt_pkg::TIM2_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            initStart_reg <= 1'b0;
        end else begin
            initStart_reg <= wrTiming && paddr == ddrt_pkg::OFS_TIM1 &&
                pwdata[ddrt_pkg::WR_LSB +: ddrt_pkg::WR_W] !=
                tim1_reg[ddrt_pkg::WR_LSB +: ddrt_pkg::WR_W];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            srMeta_reg <= 1'b0;
            srSync_reg <= 1'b0;
        end else begin
            srMeta_reg <= (linkState_reg == ddrt_pkg::LINK_SELFREF);
            srSync_reg <= srMeta_reg;
        end
    end

    // Link reset follows system reset through two flops
    always_ff @(posedge memClk) begin
        memRstMeta_reg <= srst;
        memRst_reg <= memRstMeta_reg;
    end

    // Timing words move as one unit so fields never mix old and new
    ddrt_word_sync #(
        .W(64),
        .RST({ddrt_pkg::TIM1_RST, ddrt_pkg::TIM2_RST})
    ) u_sync (
        .srcClk(clk),
        .srcRst(srst),
        .srcData({tim1_reg, tim2_reg}),
        .srcBusy(syncBusy),
        .dstClk(memClk),
        .dstRst(memRst_reg),
        .dstData(timLink)
    );

    assign lt1 = timLink[63:32];
    assign lt2 = timLink[31:0];
    assign active = (linkState_reg == ddrt_pkg::LINK_ACTIVE);

    // A command passes only when every counter guarding it is zero
    always_comb begin
        permit = 1'b0;
        case (cmdType)
            ddrt_pkg::CMD_REFRESH: begin
                permit = active && rfcCnt_reg == '0 && rpCnt_reg == '0 &&
                    xsnrCnt_reg == '0;
            end
            ddrt_pkg::CMD_LOAD_MODE:
                permit = active && xsnrCnt_reg == '0;
            ddrt_pkg::CMD_PRECHARGE: begin
                permit = active && xsnrCnt_reg == '0 &&
                    rasCnt_reg[cmdBank] == '0 && wrCnt_reg[cmdBank] == '0 &&
                    rtpCnt_reg[cmdBank] == '0;
            end
            ddrt_pkg::CMD_ACTIVATE: begin
                permit = active && rfcCnt_reg == '0 && rpCnt_reg == '0 &&
                    rcCnt_reg[cmdBank] == '0 && rrdCnt_reg == '0 &&
                    xsnrCnt_reg == '0;
            end
            ddrt_pkg::CMD_READ: begin
                permit = active && rcdCnt_reg[cmdBank] == '0 &&
                    wtrCnt_reg == '0 && xsrdCnt_reg == '0;
            end
            ddrt_pkg::CMD_WRITE: begin
                permit = active && rcdCnt_reg[cmdBank] == '0 &&
                    xsnrCnt_reg == '0;
            end
            ddrt_pkg::CMD_SR_ENTER: permit = active && ckeCnt_reg == '0 &&
                xsnrCnt_reg == '0;
            ddrt_pkg::CMD_SR_EXIT: permit = !active && ckeCnt_reg == '0;
            default: permit = 1'b0;
        endcase
    end

    // The issue flop blocks a second grant while the request drops
    assign issue = cmdValid && permit && !cmdIssue_reg;

    always_ff @(posedge memClk) begin
        if (memRst_reg) begin
            cmdIssue_reg <= 1'b0;
            cmdIssueType_reg <= ddrt_pkg::CMD_REFRESH;
            cmdIssueBank_reg <= '0;
        end else begin
            cmdIssue_reg <= issue;
            if (issue) begin
                cmdIssueType_reg <= cmdType;
                cmdIssueBank_reg <= cmdBank;
            end
        end
    end

    always_ff @(posedge memClk) begin
        if (memRst_reg) begin
            linkState_reg <= ddrt_pkg::LINK_ACTIVE;
            memCke_reg <= 1'b1;
        end else if (issue) begin
            case (linkState_reg)
                ddrt_pkg::LINK_ACTIVE: begin
                    if (cmdType == ddrt_pkg::CMD_SR_ENTER) begin
                        linkState_reg <= ddrt_pkg::LINK_SELFREF;
                        memCke_reg <= 1'b0;
                    end
                end
                ddrt_pkg::LINK_SELFREF: begin
                    if (cmdType == ddrt_pkg::CMD_SR_EXIT) begin
                        linkState_reg <= ddrt_pkg::LINK_ACTIVE;
                        memCke_reg <= 1'b1;
                    end
                end
                default: linkState_reg <= ddrt_pkg::LINK_ACTIVE;
            endcase
        end
    end

    // Shared counters: load on the guarded event, count down to zero
    always_ff @(posedge memClk) begin
        if (memRst_reg) begin
            rfcCnt_reg <= '0;
            rpCnt_reg <= '0;
            rrdCnt_reg <= '0;
            wtrCnt_reg <= '0;
            xsnrCnt_reg <= '0;
            xsrdCnt_reg <= '0;
            ckeCnt_reg <= '0;
        end else begin
            rfcCnt_reg <= (issue && (cmdType == ddrt_pkg::CMD_REFRESH ||
                cmdType == ddrt_pkg::CMD_LOAD_MODE)) ?
                fld(lt1, ddrt_pkg::RFC_LSB, ddrt_pkg::RFC_W) :
                dec(rfcCnt_reg);
            rpCnt_reg <= (issue && cmdType == ddrt_pkg::CMD_PRECHARGE) ?
                fld(lt1, ddrt_pkg::RP_LSB, ddrt_pkg::RP_W) :
                dec(rpCnt_reg);
            rrdCnt_reg <= (issue && cmdType == ddrt_pkg::CMD_ACTIVATE) ?
                fld(lt1, ddrt_pkg::RRD_LSB, ddrt_pkg::RRD_W) :
                dec(rrdCnt_reg);
            wtrCnt_reg <= (issue && cmdType == ddrt_pkg::CMD_WRITE) ?
                fld(lt1, ddrt_pkg::WTR_LSB, ddrt_pkg::WTR_W) :
                dec(wtrCnt_reg);
            xsnrCnt_reg <= (issue && cmdType == ddrt_pkg::CMD_SR_EXIT) ?
                fld(lt2, ddrt_pkg::XSNR_LSB, ddrt_pkg::XSNR_W) :
                dec(xsnrCnt_reg);
            xsrdCnt_reg <= (issue && cmdType == ddrt_pkg::CMD_SR_EXIT) ?
                fld(lt2, ddrt_pkg::XSRD_LSB, ddrt_pkg::XSRD_W) :
                dec(xsrdCnt_reg);
            ckeCnt_reg <= (issue && (cmdType == ddrt_pkg::CMD_SR_EXIT ||
                cmdType == ddrt_pkg::CMD_SR_ENTER)) ?
                fld(lt2, ddrt_pkg::CKE_LSB, ddrt_pkg::CKE_W) :
                dec(ckeCnt_reg);
        end
    end

    // Per-bank counters
    always_ff @(posedge memClk) begin
        for (int i = 0; i < NBANK; i++) begin
            if (memRst_reg) begin
                rcdCnt_reg[i] <= '0;
                rasCnt_reg[i] <= '0;
                rcCnt_reg[i] <= '0;
                wrCnt_reg[i] <= '0;
                rtpCnt_reg[i] <= '0;
            end else begin
                if (issue && cmdBank == BANK_W'(i) &&
                    cmdType == ddrt_pkg::CMD_ACTIVATE) begin
                    rcdCnt_reg[i] <= fld(lt1, ddrt_pkg::RCD_LSB,
                        ddrt_pkg::RCD_W);
                    rasCnt_reg[i] <= fld(lt1, ddrt_pkg::RAS_LSB,
                        ddrt_pkg::RAS_W);
                    rcCnt_reg[i] <= fld(lt1, ddrt_pkg::RC_LSB,
                        ddrt_pkg::RC_W);
                end else begin
                    rcdCnt_reg[i] <= dec(rcdCnt_reg[i]);
                    rasCnt_reg[i] <= dec(rasCnt_reg[i]);
                    rcCnt_reg[i] <= dec(rcCnt_reg[i]);
                end
                if (issue && cmdBank == BANK_W'(i) &&
                    cmdType == ddrt_pkg::CMD_WRITE) begin
                    wrCnt_reg[i] <= fld(lt1, ddrt_pkg::WR_LSB,
                        ddrt_pkg::WR_W);
                end else begin
                    wrCnt_reg[i] <= dec(wrCnt_reg[i]);
                end
                if (issue && cmdBank == BANK_W'(i) &&
                    cmdType == ddrt_pkg::CMD_READ) begin
                    rtpCnt_reg[i] <= fld(lt2, ddrt_pkg::RTP_LSB,
                        ddrt_pkg::RTP_W);
                end else begin
                    rtpCnt_reg[i] <= dec(rtpCnt_reg[i]);
                end
            end
        end
    end
endmodule : ddrt_timing_enforcer

// ===== verilog/ddrt_word_sync.sv
// Handshake crossing of a slowly changing word into another clock domain
`timescale 1ns/100ps
module ddrt_word_sync #(
    parameter int W = 64,
    parameter logic [W-1:0] RST = '0
) (
    // Source domain
    input wire logic srcClk,
    input wire logic srcRst,
    input wire logic [W-1:0] srcData,
    output logic srcBusy,
    // Destination domain
    input wire logic dstClk,
    input wire logic dstRst,
    output logic [W-1:0] dstData
);
    logic [W-1:0] hold_reg;
    logic reqT_reg;
    logic ackMeta_reg;
    logic ackSync_reg;
    logic reqMeta_reg;
    logic reqSync_reg;
    logic reqSeen_reg;
    logic [W-1:0] dstData_reg;

    assign srcBusy = reqT_reg != ackSync_reg;
    assign dstData = dstData_reg;

    // Hold stays frozen while a transfer is open, so the far side
    // samples a stable word
    always_ff @(posedge srcClk) begin
        if (srcRst) begin
            hold_reg <= RST;
            reqT_reg <= 1'b0;
        end else if (!srcBusy && srcData != hold_reg) begin
            hold_reg <= srcData;
            reqT_reg <= ~reqT_reg;
        end
    end

    always_ff @(posedge srcClk) begin
        if (srcRst) begin
            ackMeta_reg <= 1'b0;
            ackSync_reg <= 1'b0;
        end else begin
            ackMeta_reg <= reqSeen_reg;
            ackSync_reg <= ackMeta_reg;
        end
    end

    always_ff @(posedge dstClk) begin
        if (dstRst) begin
            reqMeta_reg <= 1'b0;
            reqSync_reg <= 1'b0;
        end else begin
            reqMeta_reg <= reqT_reg;
            reqSync_reg <= reqMeta_reg;
        end
    end

    always_ff @(posedge dstClk) begin
        if (dstRst) begin
            reqSeen_reg <= 1'b0;
            dstData_reg <= RST;
        end else if (reqSync_reg != reqSeen_reg) begin
            reqSeen_reg <= reqSync_reg;
            dstData_reg <= hold_reg;
        end
    end
endmodule : ddrt_word_sync
